/* inc/hss_pkg.sv */
// package: constants, codes and carrier types of the high-side switch control
package hss_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned OC_FILT_NS = 16_000;
  localparam int unsigned OL_FILT_NS = 64_000;
  localparam int unsigned OC_FILT_CYC = (OC_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OL_FILT_CYC = (OL_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILT_W = 12;

  // ----------------------------------------------------------------
  // duty generators
  // ----------------------------------------------------------------
  localparam int unsigned PWM_LO_HZ = 200;
  localparam int unsigned PWM_HI_HZ = 400;
  localparam int unsigned PWM_STEPS = 256;
  localparam int unsigned DUTY_W = 8;
  localparam int unsigned TICK_CYC = CLK_HZ / (PWM_HI_HZ * PWM_STEPS);
  localparam int unsigned TICK_W = 10;
  localparam int unsigned NUM_GEN = 2;
  localparam int unsigned NUM_CH = 4;

  // ----------------------------------------------------------------
  // channel source codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_ON = 3'h1;
  localparam logic [2:0] SEL_TMR1 = 3'h2;
  localparam logic [2:0] SEL_TMR2 = 3'h3;
  localparam logic [2:0] SEL_GEN_A = 3'h4;
  localparam logic [2:0] SEL_GEN_B = 3'h5;

  // ----------------------------------------------------------------
  // system mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_STOP = 3'h1;
  localparam logic [2:0] MODE_SLEEP = 3'h3;
  localparam logic [2:0] MODE_RESTART = 3'h2;
  localparam logic [2:0] MODE_FAILSAFE = 3'h6;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef logic [2:0] hss_sel_t;

  // ch[0], ch[1] form switch_control_a; ch[2], ch[3] form switch_control_b
  typedef struct packed {
    hss_sel_t [3:0] ch;
  } hss_ctrl_t;

  typedef struct packed {
    logic [1:0][7:0] duty;
    logic [1:0] freq_hi;
  } hss_pwm_t;

  typedef struct packed {
    logic ov_dis;
    logic uv_dis;
    logic rec_en;
  } hss_cfg_t;

  localparam hss_ctrl_t CTRL_RST = '0;
  localparam hss_pwm_t PWM_RST = '0;
  localparam hss_cfg_t CFG_RST = '0;

endpackage

/* rtl/hss_switch_ctrl.sv */
// four-channel high-side switch control with duty generators and protection
`timescale 1ns/10ps

module hss_switch_ctrl #(
  parameter int unsigned OC_CYC = hss_pkg::OC_FILT_CYC,
  parameter int unsigned OL_CYC = hss_pkg::OL_FILT_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [2:0] mode_i,
  input wire logic ctrl_wr_i,
  input wire hss_pkg::hss_ctrl_t ctrl_wdata_i,
  input wire logic pwm_wr_i,
  input wire hss_pkg::hss_pwm_t pwm_wdata_i,
  input wire logic cfg_wr_i,
  input wire hss_pkg::hss_cfg_t cfg_wdata_i,
  input wire logic timer1_i,
  input wire logic timer2_i,
  input wire logic supply_ov_i,
  input wire logic supply_uv_i,
  input wire logic [3:0] overcurrent_i,
  input wire logic [3:0] low_current_i,
  input wire logic [3:0] oc_clr_i,
  input wire logic [3:0] ol_clr_i,
  input wire logic [1:0] supply_flag_clr_i,
  output logic [3:0] hs_on_o,
  output hss_pkg::hss_ctrl_t switch_control_o,
  output logic [3:0] overcurrent_status_o,
  output logic [3:0] open_load_status_o,
  output logic switch_supply_overvoltage_flag_o,
  output logic switch_supply_undervoltage_flag_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic sel_drive(input hss_pkg::hss_sel_t sel, input logic t1,
                                     input logic t2, input logic ga, input logic gb);
    logic r;
    r = 1'b0;
    case (sel)
      hss_pkg::SEL_ON: r = 1'b1;
      hss_pkg::SEL_TMR1: r = t1;
      hss_pkg::SEL_TMR2: r = t2;
      hss_pkg::SEL_GEN_A: r = ga;
      hss_pkg::SEL_GEN_B: r = gb;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [hss_pkg::FILT_W-1:0] filt_next(
    input logic cond, input logic [hss_pkg::FILT_W-1:0] cnt, input int unsigned lim);
    logic [hss_pkg::FILT_W-1:0] r;
    r = '0;
    if (cond && (cnt != lim[hss_pkg::FILT_W-1:0])) begin
      r = cnt + 1'b1;
    end else if (cond) begin
      r = cnt;
    end
    return r;
  endfunction

  localparam logic [hss_pkg::FILT_W-1:0] OC_LAST = hss_pkg::FILT_W'(OC_CYC - 1);
  localparam logic [hss_pkg::FILT_W-1:0] OL_LAST = hss_pkg::FILT_W'(OL_CYC - 1);
  localparam logic [hss_pkg::TICK_W-1:0] TICK_LAST = hss_pkg::TICK_W'(hss_pkg::TICK_CYC - 1);

  // ----------------------------------------------------------------
  // synchronisers for analog comparator inputs
  // ----------------------------------------------------------------
  logic [9:0] sync1_q;
  logic [9:0] sync2_q;

  // comparator levels arrive unrelated to the clock
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {supply_ov_i, supply_uv_i, overcurrent_i, low_current_i};
      sync2_q <= sync1_q;
    end
  end

  wire ov_s = sync2_q[9];
  wire uv_s = sync2_q[8];
  wire [3:0] oc_s = sync2_q[7:4];
  wire [3:0] lowi_s = sync2_q[3:0];

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic fail_mode_q;
  wire mode_normal = (mode_i == hss_pkg::MODE_NORMAL);
  wire fail_mode = (mode_i == hss_pkg::MODE_RESTART) || (mode_i == hss_pkg::MODE_FAILSAFE);
  wire fail_entry = fail_mode && !fail_mode_q;
  // stop and sleep gate only the register writes: generators and protection run on
  wire ctrl_wr_ok = ctrl_wr_i && mode_normal;
  wire pwm_wr_ok = pwm_wr_i && mode_normal;
  wire cfg_wr_ok = cfg_wr_i && mode_normal;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  hss_pkg::hss_ctrl_t ctrl_q;
  hss_pkg::hss_ctrl_t ctrl_d;
  hss_pkg::hss_pwm_t pwm_q;
  hss_pkg::hss_cfg_t cfg_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwm_q <= hss_pkg::PWM_RST;
    end else begin
      if (pwm_wr_ok) begin
        pwm_q <= pwm_wdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_q <= hss_pkg::CFG_RST;
    end else begin
      if (cfg_wr_ok) begin
        cfg_q <= cfg_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // supply fault shutdown
  // ----------------------------------------------------------------
  logic fault_q;
  wire ov_act = ov_s && !cfg_q.ov_dis;
  wire uv_act = uv_s && !cfg_q.uv_dis;
  wire fault = ov_act || uv_act;
  // unless rec_en is set, fields are wiped on release so readback still shows the setting during the fault
  wire fault_release = fault_q && !fault;
  wire supply_wipe = fault_release && !cfg_q.rec_en;

  // ----------------------------------------------------------------
  // duty generators
  // ----------------------------------------------------------------
  logic [hss_pkg::TICK_W-1:0] tick_cnt_q;
  logic half_q;
  logic [1:0][hss_pkg::DUTY_W-1:0] gen_cnt_q;
  logic [1:0] gen_out_q;
  wire tick = (tick_cnt_q == TICK_LAST);
  wire [1:0] gen_adv = {2{tick}} & (pwm_q.freq_hi | {2{half_q}});

  // the prescaler truncates, so both rates run a hair fast
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_q <= '0;
      half_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
      half_q <= half_q ^ tick;
    end
  end

  // generators free-run so an assigned channel picks up the waveform at once
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gen_cnt_q <= '0;
    end else begin
      for (int g = 0; g < hss_pkg::NUM_GEN; g++) begin
        if (gen_adv[g]) begin
          gen_cnt_q[g] <= gen_cnt_q[g] + 1'b1;
        end
      end
    end
  end

  // registered compare so the selector never sees a carry ripple
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gen_out_q <= '0;
    end else begin
      for (int g = 0; g < hss_pkg::NUM_GEN; g++) begin
        gen_out_q[g] <= (gen_cnt_q[g] < pwm_q.duty[g]);
      end
    end
  end

  // ----------------------------------------------------------------
  // output drive
  // ----------------------------------------------------------------
  logic [3:0] hs_on_q;
  logic [3:0] drive;

  always_comb begin
    drive = '0;
    for (int i = 0; i < hss_pkg::NUM_CH; i++) begin
      drive[i] = sel_drive(ctrl_q.ch[i], timer1_i, timer2_i,
                           gen_out_q[0], gen_out_q[1]);
    end
    if (fault || fail_mode) begin
      drive = '0;
    end
  end

  // ----------------------------------------------------------------
  // overcurrent and open-load filters
  // ----------------------------------------------------------------
  logic [3:0][hss_pkg::FILT_W-1:0] oc_cnt_q;
  logic [3:0][hss_pkg::FILT_W-1:0] ol_cnt_q;
  logic [3:0] oc_cond;
  logic [3:0] ol_cond;
  logic [3:0] oc_trip;
  logic [3:0] ol_trip;

  always_comb begin
    oc_cond = hs_on_q & oc_s;
    ol_cond = hs_on_q & lowi_s;
    oc_trip = '0;
    ol_trip = '0;
    for (int i = 0; i < hss_pkg::NUM_CH; i++) begin
      oc_trip[i] = oc_cond[i] && (oc_cnt_q[i] == OC_LAST);
      ol_trip[i] = ol_cond[i] && (ol_cnt_q[i] == OL_LAST);
    end
  end

  // any clean sample restarts a filter, so chatter alone never trips it
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oc_cnt_q <= '0;
      ol_cnt_q <= '0;
    end else begin
      for (int i = 0; i < hss_pkg::NUM_CH; i++) begin
        oc_cnt_q[i] <= filt_next(oc_cond[i], oc_cnt_q[i], OC_CYC - 1);
        ol_cnt_q[i] <= filt_next(ol_cond[i], ol_cnt_q[i], OL_CYC - 1);
      end
    end
  end

  // ----------------------------------------------------------------
  // channel control fields
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr_ok) begin
      ctrl_d = ctrl_wdata_i;
    end
    for (int i = 0; i < hss_pkg::NUM_CH; i++) begin
      if (oc_trip[i]) begin
        ctrl_d.ch[i] = hss_pkg::SEL_OFF;
      end
    end
    if (fail_entry || supply_wipe) begin
      ctrl_d = hss_pkg::CTRL_RST;
    end
  end

  // ----------------------------------------------------------------
  // state and sticky flags
  // ----------------------------------------------------------------
  logic [3:0] oc_flag_q;
  logic [3:0] ol_flag_q;
  logic ov_flag_q;
  logic uv_flag_q;

  // a set in the same cycle as a clear wins, so no event is lost
  wire [3:0] oc_flag_d = (oc_flag_q & ~oc_clr_i) | oc_trip;
  wire [3:0] ol_flag_d = (ol_flag_q & ~ol_clr_i) | ol_trip;
  wire ov_flag_d = (ov_flag_q && !supply_flag_clr_i[1]) || ov_s;
  wire uv_flag_d = (uv_flag_q && !supply_flag_clr_i[0]) || uv_s;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= hss_pkg::CTRL_RST;
      fail_mode_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      fail_mode_q <= fail_mode;
      fault_q <= fault;
    end
  end

  // the drive is registered so the pins never see a decode glitch
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hs_on_q <= '0;
    end else begin
      hs_on_q <= drive;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oc_flag_q <= '0;
      ol_flag_q <= '0;
    end else begin
      oc_flag_q <= oc_flag_d;
      ol_flag_q <= ol_flag_d;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ov_flag_q <= 1'b0;
      uv_flag_q <= 1'b0;
    end else begin
      ov_flag_q <= ov_flag_d;
      uv_flag_q <= uv_flag_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hs_on_o = hs_on_q;
  assign switch_control_o = ctrl_q;
  assign overcurrent_status_o = oc_flag_q;
  assign open_load_status_o = ol_flag_q;
  assign switch_supply_overvoltage_flag_o = ov_flag_q;
  assign switch_supply_undervoltage_flag_o = uv_flag_q;

endmodule

/* sim/hss_switch_ctrl_monitor.sv */
// checker of the switch control port behaviour
`timescale 1ns/10ps
module hss_switch_ctrl_monitor #(
  parameter int unsigned OC_CYC = 8
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [2:0] mode_i,
  input wire logic ctrl_wr_i,
  input wire hss_pkg::hss_ctrl_t ctrl_wdata_i,
  input wire logic cfg_wr_i,
  input wire hss_pkg::hss_cfg_t cfg_wdata_i,
  input wire logic supply_ov_i,
  input wire logic supply_uv_i,
  input wire logic [3:0] overcurrent_i,
  input wire logic [3:0] oc_clr_i,
  input wire logic [3:0] ol_clr_i,
  input wire logic [3:0] hs_on_o,
  input wire hss_pkg::hss_ctrl_t switch_control_o,
  input wire logic [3:0] overcurrent_status_o,
  input wire logic [3:0] open_load_status_o,
  input wire logic switch_supply_overvoltage_flag_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // ----
  // helper state
  // ----
  hss_pkg::hss_cfg_t cfg_q;
  logic [15:0] oc_run_q;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_q <= hss_pkg::CFG_RST;
      oc_run_q <= 16'h0;
    end else begin
      // mirrors the accepted configuration, the ports do not show it
      if (cfg_wr_i && mode_i == hss_pkg::MODE_NORMAL) cfg_q <= cfg_wdata_i;
      oc_run_q <= (overcurrent_i[0] && hs_on_o[0]) ? oc_run_q + 16'h1 : 16'h0;
    end
  end
  wire fault_w = (supply_ov_i && !cfg_q.ov_dis) || (supply_uv_i && !cfg_q.uv_dis);
  wire fail_w = mode_i == hss_pkg::MODE_RESTART || mode_i == hss_pkg::MODE_FAILSAFE;
  wire low_w = mode_i == hss_pkg::MODE_STOP || mode_i == hss_pkg::MODE_SLEEP;
  sequence fault_held_s;
    fault_w [*3];
  endsequence
  sequence trip_s;
    switch_control_o.ch[0] == hss_pkg::SEL_OFF ##1 !hs_on_o[0];
  endsequence
  fault_off_a: assert property (fault_held_s |=> hs_on_o == 4'h0)
    else $error("output on during supply fault");
  fail_off_a: assert property (fail_w |=> hs_on_o == 4'h0 && switch_control_o == 12'h0)
    else $error("output or field kept in fail mode");
  low_refuse_a: assert property (ctrl_wr_i && low_w |=> $stable(switch_control_o))
    else $error("write taken in low power mode");
  write_take_a: assert property (ctrl_wr_i && mode_i == hss_pkg::MODE_NORMAL
    && !supply_ov_i && !supply_uv_i && overcurrent_i == 4'h0
    |=> switch_control_o == $past(ctrl_wdata_i)) else $error("write lost");
  trip_a: assert property ($rose(overcurrent_status_o[0]) |-> trip_s)
    else $error("trip left output or field on");
  oc_bound_a: assert property (oc_run_q <= OC_CYC + 8)
    else $error("overcurrent not shut down in time");
  oc_hold_a: assert property (1'b1 |=>
    ($past(overcurrent_status_o) & ~$past(oc_clr_i) & ~overcurrent_status_o) == 4'h0)
    else $error("overcurrent flag lost");
  ol_hold_a: assert property (1'b1 |=>
    ($past(open_load_status_o) & ~$past(ol_clr_i) & ~open_load_status_o) == 4'h0)
    else $error("open load flag lost");
  ol_on_a: assert property ($rose(open_load_status_o[2]) |-> $past(hs_on_o[2]))
    else $error("open load flagged while off");
  ov_flag_a: assert property ($rose(supply_ov_i) |-> ##[1:4] switch_supply_overvoltage_flag_o)
    else $error("overvoltage flag missing");
endmodule
bind hss_switch_ctrl hss_switch_ctrl_monitor #(.OC_CYC(OC_CYC)) i_mon (.mclk_i, .rst_b_i,
  .mode_i, .ctrl_wr_i, .ctrl_wdata_i, .cfg_wr_i, .cfg_wdata_i, .supply_ov_i, .supply_uv_i,
  .overcurrent_i, .oc_clr_i, .ol_clr_i, .hs_on_o, .switch_control_o, .overcurrent_status_o,
  .open_load_status_o, .switch_supply_overvoltage_flag_o);

/* sim/hss_load_model.sv */
// load model on the four switch outputs
`timescale 1ns/10ps
module hss_load_model (
  input wire logic [3:0] hs_on_i,
  input wire logic [3:0] short_i,
  input wire logic [3:0] open_i,
  output logic [3:0] overcurrent_o,
  output logic [3:0] low_current_o
);
  // an unpowered load draws nothing, so it reads as low current
  assign overcurrent_o = hs_on_i & short_i;
  assign low_current_o = ~hs_on_i | open_i;
endmodule

/* sim/tb_top.sv */
// self-checking bench of the switch control
`timescale 1ns/10ps
module tb_top;
  localparam int unsigned TK = hss_pkg::TICK_CYC;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [2:0] mode_i = 3'h0;
  logic ctrl_wr_i = 1'b0;
  logic pwm_wr_i = 1'b0;
  logic cfg_wr_i = 1'b0;
  hss_pkg::hss_ctrl_t ctrl_wdata_i = 12'h0;
  hss_pkg::hss_pwm_t pwm_wdata_i = 18'h0;
  hss_pkg::hss_cfg_t cfg_wdata_i = 3'h0;
  logic timer1_i = 1'b0;
  logic timer2_i = 1'b0;
  logic supply_ov_i = 1'b0;
  logic supply_uv_i = 1'b0;
  logic [3:0] oc_clr_i = 4'h0;
  logic [3:0] ol_clr_i = 4'h0;
  logic [1:0] supply_flag_clr_i = 2'h0;
  logic [3:0] ld_short = 4'h0;
  logic [3:0] ld_open = 4'h0;
  logic [3:0] overcurrent_i, low_current_i, hs_on_o, overcurrent_status_o, open_load_status_o;
  hss_pkg::hss_ctrl_t switch_control_o;
  logic switch_supply_overvoltage_flag_o, switch_supply_undervoltage_flag_o;
  logic [2:0] md [4] = '{3'h1, 3'h3, 3'h2, 3'h6};
  int n_mismatch = 0;
  int tests_run = 0;
  hss_switch_ctrl #(.OC_CYC(8), .OL_CYC(16)) i_dut (.mclk_i, .rst_b_i, .mode_i, .ctrl_wr_i,
    .ctrl_wdata_i, .pwm_wr_i, .pwm_wdata_i, .cfg_wr_i, .cfg_wdata_i, .timer1_i, .timer2_i,
    .supply_ov_i, .supply_uv_i, .overcurrent_i, .low_current_i, .oc_clr_i, .ol_clr_i,
    .supply_flag_clr_i, .hs_on_o, .switch_control_o, .overcurrent_status_o,
    .open_load_status_o, .switch_supply_overvoltage_flag_o, .switch_supply_undervoltage_flag_o);
  hss_load_model i_load (.hs_on_i(hs_on_o), .short_i(ld_short), .open_i(ld_open),
    .overcurrent_o(overcurrent_i), .low_current_o(low_current_i));
  // ----
  // shared tasks
  // ----
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic wr(input logic [2:0] w, input logic [11:0] c, input logic [17:0] p,
      input logic [2:0] f);
    @(posedge mclk_i);
    {ctrl_wr_i, pwm_wr_i, cfg_wr_i} <= w;
    ctrl_wdata_i <= c;
    pwm_wdata_i <= p;
    cfg_wdata_i <= f;
    @(posedge mclk_i);
    {ctrl_wr_i, pwm_wr_i, cfg_wr_i} <= 3'h0;
    wait_n(2);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic s_pwm;
    int na = 0;
    int nb = 0;
    wr(3'h2, 12'h0, {8'h03, 8'h02, 2'h1}, 3'h0);
    wr(3'h4, 12'h160, 18'h0, 3'h0);
    check(hs_on_o[2:1], 2'h3);
    repeat (7 * TK) begin
      @(negedge mclk_i);
      na += hs_on_o[1];
      nb += hs_on_o[2];
    end
    check(na > TK / 2 && na <= 2 * TK, 1'b1);
    check(nb > 4 * TK && nb <= 6 * TK, 1'b1);
  endtask
  task automatic s_src;
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 8; c++) begin
        @(posedge mclk_i);
        timer1_i <= t[0];
        timer2_i <= !t[0];
        wr(3'h4, {c[2:0], 9'h0}, 18'h0, 3'h0);
        check(hs_on_o[3], c == 1 || (c == 2 && t == 1) || (c == 3 && t == 0));
      end
    end
  endtask
  task automatic s_mode;
    for (int i = 0; i < 4; i++) begin
      wr(3'h4, 12'h001, 18'h0, 3'h0);
      @(posedge mclk_i);
      mode_i <= md[i];
      wr(3'h4, 12'h000, 18'h0, 3'h0);
      check(switch_control_o, (i < 2) ? 12'h001 : 12'h000);
      check(hs_on_o[0], i < 2);
      @(posedge mclk_i);
      mode_i <= 3'h0;
    end
  endtask
  task automatic s_oc;
    wr(3'h4, 12'h001, 18'h0, 3'h0);
    @(posedge mclk_i);
    ld_short <= 4'h1;
    for (int i = 0; i < 100 && overcurrent_status_o[0] !== 1'b1; i++) wait_n(1);
    wait_n(2);
    check({overcurrent_status_o, hs_on_o, switch_control_o[3:0]}, 12'h100);
    @(posedge mclk_i);
    ld_short <= 4'h0;
    wait_n(20);
    check(overcurrent_status_o, 4'h1);
    @(posedge mclk_i);
    oc_clr_i <= 4'h1;
    @(posedge mclk_i);
    oc_clr_i <= 4'h0;
    wr(3'h4, 12'h001, 18'h0, 3'h0);
    check({overcurrent_status_o, hs_on_o}, 8'h01);
  endtask
  task automatic s_ol;
    wr(3'h4, 12'h040, 18'h0, 3'h0);
    @(posedge mclk_i);
    ld_open <= 4'h4;
    for (int i = 0; i < 100 && open_load_status_o[2] !== 1'b1; i++) wait_n(1);
    wait_n(10);
    check({open_load_status_o, hs_on_o}, 8'h44);
    @(posedge mclk_i);
    ld_open <= 4'h0;
    wr(3'h4, 12'h000, 18'h0, 3'h0);
    wait_n(40);
    check(open_load_status_o, 4'h4);
    @(posedge mclk_i);
    ol_clr_i <= 4'h4;
    @(posedge mclk_i);
    ol_clr_i <= 4'h0;
    wait_n(40);
    check(open_load_status_o, 4'h0);
  endtask
  task automatic s_sup(input logic [2:0] f, input logic ov, input logic [11:0] e);
    logic keep = ov ? f[2] : f[1];
    wr(3'h5, 12'h001, 18'h0, f);
    @(posedge mclk_i);
    {supply_ov_i, supply_uv_i} <= {ov, !ov};
    wait_n(6);
    check({overcurrent_status_o, open_load_status_o, hs_on_o}, {8'h0, 3'h0, keep});
    check({switch_supply_overvoltage_flag_o, switch_supply_undervoltage_flag_o}, {ov, !ov});
    @(posedge mclk_i);
    {supply_ov_i, supply_uv_i} <= 2'h0;
    wait_n(6);
    check(switch_control_o, e);
    check(hs_on_o[0], e[0]);
    @(posedge mclk_i);
    supply_flag_clr_i <= 2'h3;
    @(posedge mclk_i);
    supply_flag_clr_i <= 2'h0;
    wait_n(1);
    check({switch_supply_overvoltage_flag_o, switch_supply_undervoltage_flag_o}, 2'h0);
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    wait_n(1);
    check({hs_on_o, overcurrent_status_o, open_load_status_o}, 12'h0);
    s_pwm();
    s_src();
    s_mode();
    s_oc();
    s_ol();
    s_sup(3'h1, 1'b1, 12'h001);
    s_sup(3'h0, 1'b0, 12'h000);
    s_sup(3'h2, 1'b0, 12'h001);
    s_sup(3'h4, 1'b1, 12'h001);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    complete_run();
  end
endmodule
